// ### rtl/pmic_consts.vh
/*
  Shared constants for the serial register slave and mode sequencer.
  Assumes inclusion by bare name from the design files.
*/
`ifndef PMIC_CONSTS_VH
`define PMIC_CONSTS_VH

`define DEV_ADDR 7'h60
`define DIR_WRITE 1'b0
`define DIR_READ 1'b1
`define BYTE_BITS 4'h8
`define ACK_BIT 4'h8
`define REG_IDX_RST 8'h00
`define REG_DATA_RST 8'h00
`define MODE_SHUTDOWN 2'h0
`define MODE_OTP_LOAD 2'h1
`define MODE_STANDBY 2'h2
`define MODE_ACTIVE 2'h3
`define OTP_LOAD_CYCLES 8'h10
`define UVLO_RISE_CYCLES 12'h12C
`define FIFO_DEPTH 16
`define FIFO_AW 4

`endif

// ### rtl/pmic_i2c_slave.v
/*
  Serial register slave with operating-mode sequencer and write FIFO.
  Assumes SCL, SDA input and the supply comparator are asynchronous pins;
  the outside world resolves the open-drain SDA wire from o_sda_oe_n.
*/
`include "pmic_consts.vh"

module pmic_wr_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire i_mclk,
  input wire i_arst_n,
  input wire i_ce,
  input wire i_in_valid,
  output wire o_in_ready,
  input wire [WIDTH-1:0] i_in_data,
  output wire o_out_valid,
  input wire i_out_ready,
  output wire [WIDTH-1:0] o_out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wptr_r;
  reg [AW:0] rptr_r;

  // Pointer compare with wrap bit
  wire full = (wptr_r[AW] != rptr_r[AW]) &&
              (wptr_r[AW-1:0] == rptr_r[AW-1:0]);
  wire empty = (wptr_r == rptr_r);
  assign o_in_ready = ~full;
  assign o_out_valid = ~empty;
  assign o_out_data = mem[rptr_r[AW-1:0]];

  // Storage array, no reset needed
  always @(posedge i_mclk) begin
    if (i_ce && i_in_valid && !full) begin
      mem[wptr_r[AW-1:0]] <= i_in_data;
    end
  end

  // Pointers
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wptr_r <= {(AW+1){1'b0}};
      rptr_r <= {(AW+1){1'b0}};
    end else if (i_ce) begin
      if (i_in_valid && !full) begin
        wptr_r <= wptr_r + 1'b1;
      end
      if (i_out_ready && !empty) begin
        rptr_r <= rptr_r + 1'b1;
      end
    end
  end
endmodule

// Functional notes
// (R1) Below lockout threshold the device stays in shutdown, everything off.
// (R2) Above threshold, enter OTP load, regulators off, defaults loaded.
// (R3) Standby: regulators off, registers accessible, enable requests accepted.
// (R4) Active whenever supply good and at least one regulator enabled.
// (R5) Slave works up to 3.4 MHz bus clock.
// (R6) SDA changes only while SCL low, stable while SCL high.
// (R7) START is SDA fall with SCL high; STOP is SDA rise.
// (R8) Master makes START and STOP; repeated START acts as START.
// (R9) Bus busy from START until STOP, free afterwards.
// (R10) Bytes are eight bits, MSB first, then one acknowledge slot.
// (R11) Master clocks the acknowledge slot and releases SDA.
// (R12) Slave pulls SDA low in ninth pulse after each received byte.
// (R13) Master reader ends with not-acknowledge on the last byte.
// (R14) Under lockout the slave never drives SDA.
// (R15) First byte: 7-bit address then direction, 0 write, 1 read.
// (R16) Only the fixed bus address is answered; others ignored.
// (R17) Write: byte after address is index, next byte is data.
// (R18) Reads need a preceding index write and repeated START.
// (R19) Index increments by one after each stored write byte.
// (R20) Index does not advance during reads.
// (R21) Supply loss disables regulators at once; recovery goes via OTP load.
// (R22) Standby to active on any enable; back once all disabled.
// (R23) Read phase shifts out the selected register, MSB first.
module pmic_i2c_slave #(
  parameter NUM_REGS = 256,
  parameter NUM_REGU = 4,
  parameter REGU_IDX = 8'h02
) (
  input wire i_mclk,
  input wire i_arst_n,
  input wire i_ce,
  input wire i_scl,
  input wire i_sda,
  output reg o_sda_oe_n,
  input wire i_supply_above_lockout,
  output reg [1:0] o_mode,
  output reg o_bus_busy,
  output reg [NUM_REGU-1:0] o_regu_en,
  output reg o_wr_valid,
  output reg [15:0] o_wr_data,
  input wire i_wr_ready
);
  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_INDEX = 3'h2;
  localparam ST_WDATA = 3'h3;
  localparam ST_RDATA = 3'h4;
  localparam ST_IGNORE = 3'h5;
  localparam [11:0] UVLO_CNT = `UVLO_RISE_CYCLES;

  // Synchronisers, two stages each
  reg scl_s1_r;
  reg scl_s2_r;
  reg scl_d_r;
  reg sda_s1_r;
  reg sda_s2_r;
  reg sda_d_r;
  reg sup_s1_r;
  reg sup_s2_r;
  reg [11:0] uvlo_cnt_r;
  reg supply_ok_r;
  reg [7:0] otp_cnt_r;
  reg [2:0] state_r;
  reg [3:0] bit_cnt_r;
  reg [7:0] shift_r;
  reg [7:0] index_r;
  reg [7:0] regs [0:NUM_REGS-1];
  reg in_ack_r;
  reg ack_drive_r;
  reg rd_drive_r;
  reg rd_bit_r;
  reg nack_seen_r;
  wire scl_rise;
  wire scl_fall;
  wire start_det;
  wire stop_det;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [15:0] fifo_out_data;
  integer k;

  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      sda_d_r <= 1'b1;
      sup_s1_r <= 1'b0;
      sup_s2_r <= 1'b0;
    end else if (i_ce) begin
      scl_s1_r <= i_scl;
      scl_s2_r <= scl_s1_r;
      scl_d_r <= scl_s2_r;
      sda_s1_r <= i_sda;
      sda_s2_r <= sda_s1_r;
      sda_d_r <= sda_s2_r;
      sup_s1_r <= i_supply_above_lockout;
      sup_s2_r <= sup_s1_r;
    end
  end

  // Edge and condition detection on the synchronised lines
  assign scl_rise = scl_s2_r & ~scl_d_r; // [R5]
  assign scl_fall = ~scl_s2_r & scl_d_r;
  assign start_det = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r; // [R7] [R8]
  assign stop_det = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r; // [R7]

  // Supply qualifier: rising needs a debounce window, falling is immediate
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      uvlo_cnt_r <= 12'h000;
      supply_ok_r <= 1'b0;
    end else if (i_ce) begin
      if (!sup_s2_r) begin
        uvlo_cnt_r <= 12'h000;
        supply_ok_r <= 1'b0; // [R21]
      end else if (uvlo_cnt_r < UVLO_CNT) begin
        uvlo_cnt_r <= uvlo_cnt_r + 12'h001;
      end else begin
        supply_ok_r <= 1'b1;
      end
    end
  end

  // Operating-mode sequencer
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_mode <= `MODE_SHUTDOWN;
      otp_cnt_r <= 8'h00;
    end else if (i_ce) begin
      if (!supply_ok_r) begin
        o_mode <= `MODE_SHUTDOWN; // [R1] [R21]
        otp_cnt_r <= 8'h00;
      end else begin
        case (o_mode)
          `MODE_SHUTDOWN: o_mode <= `MODE_OTP_LOAD; // [R2]
          `MODE_OTP_LOAD: begin
            if (otp_cnt_r == `OTP_LOAD_CYCLES) begin
              o_mode <= `MODE_STANDBY;
            end else begin
              otp_cnt_r <= otp_cnt_r + 8'h01;
            end
          end
          `MODE_STANDBY: begin
            if (|o_regu_en) begin
              o_mode <= `MODE_ACTIVE; // [R22] [R4]
            end
          end
          `MODE_ACTIVE: begin
            if (~|o_regu_en) begin
              o_mode <= `MODE_STANDBY; // [R22]
            end
          end
          default: o_mode <= `MODE_SHUTDOWN;
        endcase
      end
    end
  end

  // Writes reach the register array through the FIFO
  pmic_wr_fifo #(
    .WIDTH(16),
    .DEPTH(`FIFO_DEPTH),
    .AW(`FIFO_AW)
  ) u_fifo (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .i_ce(i_ce),
    .i_in_valid(o_wr_valid),
    .o_in_ready(fifo_in_ready),
    .i_in_data(o_wr_data),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(i_wr_ready),
    .o_out_data(fifo_out_data)
  );

  // Register array; OTP load restores defaults, stores drained from FIFO
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_regu_en <= {NUM_REGU{1'b0}};
    end else if (i_ce) begin
      if (!supply_ok_r || o_mode < `MODE_STANDBY) begin
        o_regu_en <= {NUM_REGU{1'b0}}; // [R1] [R2] [R21]
      end else if (fifo_out_valid && i_wr_ready &&
                   fifo_out_data[15:8] == REGU_IDX) begin
        o_regu_en <= fifo_out_data[NUM_REGU-1:0]; // [R3]
      end
    end
  end

  always @(posedge i_mclk) begin
    if (i_ce) begin
      if (o_mode == `MODE_OTP_LOAD) begin
        for (k = 0; k < NUM_REGS; k = k + 1) begin
          regs[k] <= `REG_DATA_RST; // [R2]
        end
      end else if (fifo_out_valid && i_wr_ready) begin
        regs[fifo_out_data[15:8]] <= fifo_out_data[7:0]; // [R3] [R4]
      end
    end
  end

  // Serial protocol engine
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_r <= ST_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      index_r <= `REG_IDX_RST;
      in_ack_r <= 1'b0;
      ack_drive_r <= 1'b0;
      rd_drive_r <= 1'b0;
      rd_bit_r <= 1'b1;
      nack_seen_r <= 1'b0;
      o_bus_busy <= 1'b0;
      o_wr_valid <= 1'b0;
      o_wr_data <= 16'h0000;
    end else if (i_ce) begin
      if (o_wr_valid && fifo_in_ready) begin
        o_wr_valid <= 1'b0;
      end
      if (!supply_ok_r) begin
        state_r <= ST_IDLE;
        ack_drive_r <= 1'b0; // [R14]
        rd_drive_r <= 1'b0;
        o_bus_busy <= 1'b0;
      end else if (start_det) begin
        state_r <= ST_ADDR; // [R8]
        bit_cnt_r <= 4'h0;
        in_ack_r <= 1'b0;
        ack_drive_r <= 1'b0;
        rd_drive_r <= 1'b0;
        o_bus_busy <= 1'b1; // [R9]
      end else if (stop_det) begin
        state_r <= ST_IDLE;
        ack_drive_r <= 1'b0;
        rd_drive_r <= 1'b0;
        o_bus_busy <= 1'b0; // [R9]
      end else if (scl_rise && state_r != ST_IDLE &&
                   state_r != ST_IGNORE) begin
        if (in_ack_r) begin
          nack_seen_r <= sda_s2_r; // [R13]
        end else begin
          shift_r <= {shift_r[6:0], sda_s2_r}; // [R10]
          bit_cnt_r <= bit_cnt_r + 4'h1;
        end
      end else if (scl_fall) begin
        // Drive changes only after SCL falls [R6]
        if (in_ack_r) begin
          in_ack_r <= 1'b0;
          ack_drive_r <= 1'b0;
          bit_cnt_r <= 4'h0;
          if (state_r == ST_RDATA) begin
            if (nack_seen_r) begin
              state_r <= ST_IGNORE; // [R13]
              rd_drive_r <= 1'b0;
            end else begin
              rd_drive_r <= 1'b1;
              rd_bit_r <= regs[index_r][7]; // [R20] [R23]
            end
          end
        end else if (bit_cnt_r == `BYTE_BITS) begin
          in_ack_r <= 1'b1;
          rd_drive_r <= 1'b0;
          case (state_r)
            ST_ADDR: begin
              if (shift_r[7:1] == `DEV_ADDR) begin // [R15] [R16]
                ack_drive_r <= 1'b1; // [R12]
                state_r <= (shift_r[0] == `DIR_READ) ? ST_RDATA : ST_INDEX;
              end else begin
                in_ack_r <= 1'b0;
                state_r <= ST_IGNORE; // [R16]
              end
            end
            ST_INDEX: begin
              ack_drive_r <= 1'b1; // [R12]
              index_r <= shift_r; // [R17] [R18]
              state_r <= ST_WDATA;
            end
            ST_WDATA: begin
              ack_drive_r <= 1'b1; // [R12]
              o_wr_valid <= 1'b1; // [R17]
              o_wr_data <= {index_r, shift_r};
              index_r <= index_r + 8'h01; // [R19]
            end
            ST_RDATA: begin
              ack_drive_r <= 1'b0; // [R11]
            end
            default: begin
              state_r <= ST_IGNORE;
            end
          endcase
        end else if (state_r == ST_RDATA && rd_drive_r) begin
          rd_bit_r <= regs[index_r][3'h7 - bit_cnt_r[2:0]]; // [R23]
        end
      end
    end
  end

  // Open-drain SDA: enable low means pull low
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_sda_oe_n <= 1'b1;
    end else if (i_ce) begin
      o_sda_oe_n <= ~(supply_ok_r &&
                      (ack_drive_r || (rd_drive_r && !rd_bit_r))); // [R14]
    end
  end
endmodule

// ### tb/pmic_i2c_props.sv
/* Checker for the serial slave and mode sequencer ports.
   Assumes binding to every pmic_i2c_slave instance. */
`include "pmic_consts.vh"
module pmic_i2c_props #(
  parameter NUM_REGU = 4
) (
  input wire i_mclk,
  input wire i_arst_n,
  input wire i_scl,
  input wire i_sda,
  input wire o_sda_oe_n,
  input wire i_supply_above_lockout,
  input wire [1:0] o_mode,
  input wire o_bus_busy,
  input wire [NUM_REGU-1:0] o_regu_en,
  input wire o_wr_valid,
  input wire i_wr_ready
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  // Supply good and bus serviced
  wire up = i_supply_above_lockout;
  wire run = o_mode[1] & up;
  a_uvlo_off: assert property (
    !up [*6] |-> o_mode == `MODE_SHUTDOWN && o_regu_en == 0)
    else $error("mode or enables on in lockout");
  a_uvlo_quiet: assert property (
    !up [*6] |-> o_sda_oe_n) else $error("data driven in lockout");
  a_otp_entry: assert property (
    $past(o_mode) == `MODE_SHUTDOWN && o_mode != `MODE_SHUTDOWN
    |-> o_mode == `MODE_OTP_LOAD && o_regu_en == 0)
    else $error("shutdown left without otp load");
  a_go_active: assert property (
    o_mode == `MODE_STANDBY && |o_regu_en |-> ##[1:4] o_mode == `MODE_ACTIVE)
    else $error("enable without active mode");
  a_go_standby: assert property (
    o_mode == `MODE_ACTIVE && o_regu_en == 0 |-> ##[1:4] o_mode != `MODE_ACTIVE)
    else $error("active with all regulators off");
  a_start_busy: assert property (
    run && i_scl && $fell(i_sda) |-> ##[1:5] o_bus_busy)
    else $error("start not seen");
  a_stop_free: assert property (
    run && i_scl && $rose(i_sda) |-> ##[1:5] !o_bus_busy)
    else $error("stop not seen");
  a_drive_scl_low: assert property (
    run && $changed(o_sda_oe_n) |-> !i_scl)
    else $error("data changed with clock high");
  a_ack_stands: assert property (
    run && $fell(o_sda_oe_n) |-> !o_sda_oe_n [*6])
    else $error("acknowledge too short");
  a_idle_quiet: assert property (
    !o_bus_busy |-> o_sda_oe_n) else $error("data driven on free bus");
  // With the drain running the FIFO takes a pending word within two cycles
  a_wr_hold: assert property (
    o_wr_valid && i_wr_ready |-> ##[1:2] !o_wr_valid)
    else $error("write word not taken");
  c_active: cover property (o_mode == `MODE_ACTIVE);
  c_ack: cover property (o_bus_busy && !o_sda_oe_n);
  c_stall: cover property (o_wr_valid && !i_wr_ready);
endmodule

bind pmic_i2c_slave pmic_i2c_props #(.NUM_REGU(NUM_REGU)) i_props (
  .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_scl(i_scl), .i_sda(i_sda),
  .o_sda_oe_n(o_sda_oe_n), .i_supply_above_lockout(i_supply_above_lockout),
  .o_mode(o_mode), .o_bus_busy(o_bus_busy), .o_regu_en(o_regu_en),
  .o_wr_valid(o_wr_valid), .i_wr_ready(i_wr_ready));

// ### tb/i2c_host_model.sv
/* Behavioural serial bus host with a 125 ns bit slot.
   Assumes a pulled-up data wire that any party may pull low. */
module i2c_host_model (
  output logic o_scl,
  output logic o_sda,
  input wire i_line
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    o_scl = 1;
    o_sda = 1;
  end
  // One bit; data moves only while the clock is low
  task automatic bit_slot(input logic b, output logic r);
    o_scl = 0;
    #30 o_sda = b;
    #32 o_scl = 1;
    #30 r = i_line;
    #33;
  endtask
  // Start and repeated start alike
  task automatic start_c;
    o_scl = 0;
    #30 o_sda = 1;
    #32 o_scl = 1;
    #60 o_sda = 0;
    #60;
  endtask
  task automatic stop_c;
    o_scl = 0;
    #30 o_sda = 0;
    #32 o_scl = 1;
    #60 o_sda = 1;
    #60;
  endtask
  // Eight bits first-bit-high, then a released acknowledge slot
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_slot(d[i], r);
    bit_slot(1'b1, r);
    ack = !r;
  endtask
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 0; i < 8; i++) begin
      bit_slot(1'b1, r);
      d = {d[6:0], r};
    end
    bit_slot(last, r);
  endtask
endmodule

// ### tb/tb.sv
/* Self-checking bench for the serial slave and mode sequencer.
   Assumes the host model and the bound checker are compiled with it. */
`include "pmic_consts.vh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_mclk = 0;
  logic i_arst_n = 0;
  logic sup = 0;
  logic rdy = 1;
  logic saw_otp = 0;
  logic scl, sda_m, ack;
  logic [7:0] d;
  wire oe_n, busy, wv;
  wire [1:0] mode;
  wire [3:0] regu;
  wire [15:0] wd;
  wire line = sda_m & oe_n;
  int bad_count = 0;
  int check_count = 0;
  logic [15:0] got_q[$];
  always #5 i_mclk = ~i_mclk;
  pmic_i2c_slave i_dut (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_ce(1'b1),
    .i_scl(scl), .i_sda(line), .o_sda_oe_n(oe_n),
    .i_supply_above_lockout(sup), .o_mode(mode), .o_bus_busy(busy),
    .o_regu_en(regu), .o_wr_valid(wv), .o_wr_data(wd), .i_wr_ready(rdy));
  i2c_host_model u_host (.o_scl(scl), .o_sda(sda_m), .i_line(line));
  // Collect a word every cycle the slave offers one on o_wr_valid, and note the load phase
  always @(posedge i_mclk) begin
    if (wv) got_q.push_back(wd);
    if (mode == `MODE_OTP_LOAD) saw_otp <= 1;
  end
  task final_report;
    if (bad_count == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task drive(input logic s, input logic r);
    @(posedge i_mclk);
    #1 sup = s;
    rdy = r;
  endtask
  // Mode is looked at one step after the edge that launches it
  task wait_mode(input logic [1:0] m);
    for (int i = 0; i < 2000 && mode !== m; i++) begin
      @(posedge i_mclk);
      #1;
    end
  endtask
  task hdr(input logic [6:0] a, input logic rw, input logic exp);
    u_host.start_c();
    u_host.wbyte({a, rw}, ack);
    `CHK(ack, exp)
  endtask
  task wb(input logic [7:0] v, input logic exp);
    u_host.wbyte(v, ack);
    `CHK(ack, exp)
  endtask
  task wreg(input logic [7:0] idx, input logic [7:0] v);
    hdr(`DEV_ADDR, `DIR_WRITE, 1'b1);
    wb(idx, 1'b1);
    wb(v, 1'b1);
    u_host.stop_c();
  endtask
  // Power-up goes through the load phase to standby
  task t_powerup;
    drive(1, 1);
    wait_mode(`MODE_STANDBY);
    `CHK(saw_otp, 1'b1)
    `CHK(mode, `MODE_STANDBY)
    `CHK(regu, 4'h0)
  endtask
  // Burst with the drain stalled, then released
  task t_burst;
    logic [7:0] v[3] = '{8'hA5, 8'h3C, 8'h7E};
    drive(1, 0);
    hdr(`DEV_ADDR, `DIR_WRITE, 1'b1);
    `CHK(busy, 1'b1)
    wb(8'h10, 1'b1);
    for (int i = 0; i < 3; i++) wb(v[i], 1'b1);
    u_host.stop_c();
    `CHK(busy, 1'b0)
    drive(1, 1);
    for (int i = 0; i < 50 && got_q.size() < 3; i++) @(posedge i_mclk);
    for (int i = 0; i < 3; i++) `CHK(got_q[i], {8'(8'h10 + i), v[i]})
    got_q.delete();
  endtask
  // Index write, repeated start, two reads of one register
  task t_read;
    hdr(`DEV_ADDR, `DIR_WRITE, 1'b1);
    wb(8'h11, 1'b1);
    hdr(`DEV_ADDR, `DIR_READ, 1'b1);
    u_host.rbyte(1'b0, d);
    `CHK(d, 8'h3C)
    u_host.rbyte(1'b1, d);
    `CHK(d, 8'h3C)
    u_host.stop_c();
  endtask
  // Enables move the mode; other addresses get no answer
  task t_modes;
    hdr(`DEV_ADDR ^ 7'h01, `DIR_WRITE, 1'b0);
    u_host.stop_c();
    wreg(8'h02, 8'h01);
    wait_mode(`MODE_ACTIVE);
    `CHK(mode, `MODE_ACTIVE)
    `CHK(regu, 4'h1)
    wreg(8'h02, 8'h00);
    wait_mode(`MODE_STANDBY);
    `CHK(mode, `MODE_STANDBY)
  endtask
  // Supply loss while active, silent bus, recovery via load
  task t_uvlo;
    wreg(8'h02, 8'h03);
    drive(0, 1);
    wait_mode(`MODE_SHUTDOWN);
    `CHK(regu, 4'h0)
    hdr(`DEV_ADDR, `DIR_WRITE, 1'b0);
    u_host.stop_c();
    saw_otp = 0;
    drive(1, 1);
    wait_mode(`MODE_STANDBY);
    `CHK(saw_otp, 1'b1)
    `CHK(regu, 4'h0)
  endtask
  initial begin
    repeat (10) @(posedge i_mclk);
    #1 i_arst_n = 1;
    t_powerup();
    t_burst();
    t_read();
    t_modes();
    t_uvlo();
    final_report();
  end
  // Watchdog well past the expected run length
  initial begin
    #300000;
    bad_count++;
    final_report();
  end
endmodule
